// >>> include/mpc_map.svh
// register addresses, field positions and encodings of the protection unit
`ifndef MPC_MAP_SVH
`define MPC_MAP_SVH
`define MPC_ADDR_RNS      32'he000ed98
`define MPC_ADDR_RBA      32'he000ed9c
`define MPC_ADDR_RAS      32'he000eda0
`define MPC_ADDR_LAST     32'he000edb8
`define MPC_RNS_W         8
`define MPC_RBA_VALID     4
`define MPC_RBA_BASE_LO   5
`define MPC_RAS_EN        0
`define MPC_RAS_SZ_HI     5
`define MPC_RAS_SZ_LO     1
`define MPC_RAS_B         16
`define MPC_RAS_C         17
`define MPC_RAS_S         18
`define MPC_RAS_TEX_HI    21
`define MPC_RAS_TEX_LO    19
`define MPC_RAS_AP_HI     26
`define MPC_RAS_AP_LO     24
`define MPC_RAS_XN        28
`define MPC_RAS_WMASK     32'h173fff3f
`define MPC_TEX_LEGACY    3'h0
`define MPC_TEX_NC        3'h1
`define MPC_TEX_DEV       3'h2
`define MPC_AP_NONE       3'h0
`define MPC_AP_PRIV       3'h1
`define MPC_AP_URO        3'h2
`define MPC_AP_FULL       3'h3
`define MPC_AP_PRO        3'h5
`define MPC_AP_RO6        3'h6
`define MPC_AP_RO7        3'h7
`define MPC_MMF_IACC      0
`define MPC_MMF_DACC      1
`define MPC_MMF_ADDRV     7
`endif

// >>> include/mpc_pkg.sv
// types shared by the protection unit
package mpc_pkg;
   // memory type of the matching region
   typedef enum logic [1:0] {
      MPC_MT_STRONG,
      MPC_MT_DEVICE,
      MPC_MT_NORMAL,
      MPC_MT_RESERVED
   } mpc_memtype_t;
   // two-bit cache policy code, order gives the code value
   typedef enum logic [1:0] {
      MPC_POL_NC,
      MPC_POL_WB_RWA,
      MPC_POL_WT,
      MPC_POL_WB
   } mpc_policy_t;
endpackage

// >>> rtl/mpc_region_check.sv
// region attribute decoder and access permission checker
`timescale 1ns/1ps
`include "mpc_map.svh"

module mpc_region_check
   import mpc_pkg::*;
#(
   parameter int NREG = 8
) (
   input  wire logic         clk_sys_in,
   input  wire logic         rstn_in,
   input  wire logic         ce_in,
   input  wire logic         reg_sel_in,
   input  wire logic         reg_wr_in,
   input  wire logic [31:0]  reg_addr_in,
   input  wire logic [3:0]   reg_be_in,
   input  wire logic [31:0]  reg_wdata_in,
   output logic      [31:0]  reg_rdata_out,
   input  wire logic         acc_valid_in,
   input  wire logic [31:0]  acc_addr_in,
   input  wire logic         acc_write_in,
   input  wire logic         acc_priv_in,
   input  wire logic         acc_fetch_in,
   output logic              acc_done_out,
   output logic              acc_fault_out,
   output mpc_memtype_t      mem_type_out,
   output logic              shareable_out,
   output mpc_policy_t       inner_pol_out,
   output mpc_policy_t       outer_pol_out,
   output logic              mmf_exc_out,
   input  wire logic         mmf_clear_in,
   output logic      [7:0]   mmf_status_out,
   output logic      [31:0]  mmf_addr_out
);
   localparam int RW = $clog2(NREG);

   //----------------------------------------------------------------
   // register file
   //----------------------------------------------------------------
   logic [`MPC_RNS_W-1:0] rns_r, rns_nxt;        // region select
   logic [31:0] base_r [NREG];                   // base per region
   logic [31:0] base_nxt [NREG];
   logic [31:0] ras_r  [NREG];                   // attribute/size
   logic [31:0] ras_nxt [NREG];
   logic [31:0] rdata_nxt;                       // read answer
   logic [31:0] roff;                            // offset from base reg
   logic [31:0] waddr;                           // word-aligned address
   logic        is_rba, is_ras;                  // decoded targets
   logic [RW-1:0] wreg;                          // region written
   logic [RW-1:0] cur;                           // selected region

   assign cur  = rns_r[RW-1:0];
   assign roff = reg_addr_in - `MPC_ADDR_RBA;
   assign waddr = {reg_addr_in[31:2], 2'h0};

   // address decode and write merge
   always_comb begin
      logic [31:0] m;
      m = 32'h0;
      rns_nxt   = rns_r;
      base_nxt  = base_r;
      ras_nxt   = ras_r;
      rdata_nxt = 32'h0;
      is_rba = reg_addr_in >= `MPC_ADDR_RBA &&
               reg_addr_in <= `MPC_ADDR_LAST && roff[3:0] == 4'h0;
      // halfword and byte stores may land inside the attribute word
      is_ras = waddr >= `MPC_ADDR_RAS &&
               waddr <= `MPC_ADDR_LAST && roff[3:2] == 2'h1;
      wreg = cur;
      if (is_rba && reg_wdata_in[`MPC_RBA_VALID])
         wreg = reg_wdata_in[RW-1:0];
      for (int i = 0; i < 4; i++)
         m[i*8 +: 8] = {8{reg_be_in[i]}};
      // burst lands one word per cycle
      if (reg_sel_in && reg_wr_in) begin
         // each register decoded on its own; a base write with VALID also sets the region number
         if (reg_addr_in == `MPC_ADDR_RNS)
            rns_nxt = reg_wdata_in[`MPC_RNS_W-1:0];
         if (is_rba) begin
            base_nxt[wreg] = {reg_wdata_in[31:`MPC_RBA_BASE_LO],
                              5'h00};
            if (reg_wdata_in[`MPC_RBA_VALID])
               rns_nxt = {{(`MPC_RNS_W-RW){1'b0}}, wreg};
         end
         if (is_ras)
            ras_nxt[cur] = ((ras_r[cur] & ~m) | (reg_wdata_in & m))
                           & `MPC_RAS_WMASK;
      end
      if (reg_sel_in && !reg_wr_in) begin
         if (reg_addr_in == `MPC_ADDR_RNS)
            rdata_nxt = {24'h0, rns_r};
         else if (is_rba)
            rdata_nxt = base_r[cur] |
                        {{(32-RW){1'b0}}, cur};
         else if (is_ras)
            rdata_nxt = ras_r[cur];
      end
   end

   // register storage, reset to zero
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rns_r         <= '0;
         reg_rdata_out <= 32'h0;
         for (int i = 0; i < NREG; i++) begin
            base_r[i] <= 32'h0;
            ras_r[i]  <= 32'h0;
         end
      end else if (ce_in) begin
         rns_r         <= rns_nxt;
         reg_rdata_out <= rdata_nxt;
         base_r        <= base_nxt;
         ras_r         <= ras_nxt;
      end
   end

   //----------------------------------------------------------------
   // region match and attribute decode
   //----------------------------------------------------------------
   logic         hit;                            // any region matched
   logic [31:0]  attr;                           // winning attributes
   logic         allow;                          // permission result
   mpc_memtype_t mt;                             // decoded type
   logic         sh;                             // decoded shareability
   mpc_policy_t  ip, op;                         // decoded policies

   always_comb begin
      logic [31:0] msk;
      logic [2:0]  type_extension_field, ap;
      logic        c, b, s, wr, pv;
      type_extension_field  = 3'h0;
      ap   = 3'h0;
      c    = 1'b0;
      b    = 1'b0;
      s    = 1'b0;
      wr   = 1'b0;
      pv   = 1'b0;
      hit  = 1'b0;
      attr = 32'h0;
      msk  = 32'h0;
      for (int i = 0; i < NREG; i++) begin
         msk = 32'hffffffff <<
               (ras_r[i][`MPC_RAS_SZ_HI:`MPC_RAS_SZ_LO] + 6'h01);
         if (ras_r[i][`MPC_RAS_EN] &&
             ((acc_addr_in ^ base_r[i]) & msk) == 32'h0) begin
            hit  = 1'b1;
            attr = ras_r[i];
         end
      end
      type_extension_field = attr[`MPC_RAS_TEX_HI:`MPC_RAS_TEX_LO];
      ap  = attr[`MPC_RAS_AP_HI:`MPC_RAS_AP_LO];
      c   = attr[`MPC_RAS_C];
      b   = attr[`MPC_RAS_B];
      s   = attr[`MPC_RAS_S];
      wr  = acc_write_in;
      pv  = acc_priv_in;
      mt  = MPC_MT_RESERVED;
      sh  = s;
      ip  = MPC_POL_NC;
      op  = MPC_POL_NC;
      if (type_extension_field[2]) begin
         // outer from tex, inner from c/b
         mt = MPC_MT_NORMAL;
         op = mpc_policy_t'(type_extension_field[1:0]);
         ip = mpc_policy_t'({c, b});
      end else begin
         case (type_extension_field)
            `MPC_TEX_LEGACY: begin
               if (!c) begin
                  mt = b ? MPC_MT_DEVICE : MPC_MT_STRONG;
                  sh = 1'b1;
               end else begin
                  mt = MPC_MT_NORMAL;
                  op = b ? MPC_POL_WB : MPC_POL_WT;
                  ip = op;
               end
            end
            `MPC_TEX_NC: begin
               if (!c && !b) mt = MPC_MT_NORMAL;
               else if (c && b) begin
                  mt = MPC_MT_NORMAL;
                  op = MPC_POL_WB_RWA;
                  ip = MPC_POL_WB_RWA;
               end
            end
            `MPC_TEX_DEV: begin
               if (!c && !b) begin
                  mt = MPC_MT_DEVICE;
                  sh = 1'b0;
               end
            end
            default: mt = MPC_MT_RESERVED;
         endcase
      end
      case (ap)
         `MPC_AP_NONE: allow = 1'b0;
         `MPC_AP_PRIV: allow = pv;
         `MPC_AP_URO:  allow = pv || !wr;
         `MPC_AP_FULL: allow = 1'b1;
         `MPC_AP_PRO:  allow = pv && !wr;
         `MPC_AP_RO6,
         `MPC_AP_RO7:  allow = !wr;
         default:      allow = 1'b0;
      endcase
      // no hit: background map, privileged only
      if (!hit) begin
         allow = pv;
         mt    = MPC_MT_STRONG;
         sh    = 1'b1;
      end else begin
         // execute-never blocks fetches
         if (acc_fetch_in && attr[`MPC_RAS_XN]) allow = 1'b0;
         if (mt == MPC_MT_RESERVED) allow = 1'b0;
      end
   end

   //----------------------------------------------------------------
   // check result and fault status
   //----------------------------------------------------------------
   logic        fault_now;                       // violation this cycle
   logic        done_nxt, fault_nxt, exc_nxt;
   logic [7:0]  mmf_nxt;
   logic [31:0] mmfa_nxt;

   assign fault_now = acc_valid_in && !allow;

   // sticky status, set beats clear
   always_comb begin
      done_nxt  = acc_valid_in;
      fault_nxt = fault_now;
      exc_nxt   = fault_now;
      mmf_nxt   = mmf_clear_in ? 8'h00 : mmf_status_out;
      mmfa_nxt  = mmf_addr_out;
      if (fault_now) begin
         mmf_nxt[acc_fetch_in ? `MPC_MMF_IACC : `MPC_MMF_DACC] = 1'b1;
         if (!acc_fetch_in) begin
            mmf_nxt[`MPC_MMF_ADDRV] = 1'b1;
            mmfa_nxt = acc_addr_in;
         end
      end
   end

   // result registers; the fault flags in the cycle after the
   // address, before the data phase of a write completes
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         acc_done_out   <= 1'b0;
         acc_fault_out  <= 1'b0;
         mmf_exc_out    <= 1'b0;
         mmf_status_out <= 8'h00;
         mmf_addr_out   <= 32'h0;
         mem_type_out   <= MPC_MT_STRONG;
         shareable_out  <= 1'b0;
         inner_pol_out  <= MPC_POL_NC;
         outer_pol_out  <= MPC_POL_NC;
      end else if (ce_in) begin
         acc_done_out   <= done_nxt;
         acc_fault_out  <= fault_nxt;
         mmf_exc_out    <= exc_nxt;
         mmf_status_out <= mmf_nxt;
         mmf_addr_out   <= mmfa_nxt;
         mem_type_out   <= mt;
         shareable_out  <= sh;
         inner_pol_out  <= ip;
         outer_pol_out  <= op;
      end
   end

   //----------------------------------------------------------------
   // checks
   //----------------------------------------------------------------
   sequence s_fault_access;
      ce_in && acc_valid_in && !allow;
   endsequence
   sequence s_flagged;
      acc_fault_out && mmf_exc_out;
   endsequence

   property p_fault_seen;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      s_fault_access |=> s_flagged;
   endproperty
   a_fault_seen: assert property (p_fault_seen)
      else $error("denied access not flagged");

   property p_ap_none;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      hit && attr[`MPC_RAS_AP_HI:`MPC_RAS_AP_LO] == `MPC_AP_NONE
      |-> !allow;
   endproperty
   a_ap_none: assert property (p_ap_none)
      else $error("no-access region allowed an access");

   property p_ap_priv;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      hit && attr[`MPC_RAS_AP_HI:`MPC_RAS_AP_LO] == `MPC_AP_PRIV &&
      !acc_fetch_in && mt != MPC_MT_RESERVED |-> allow == acc_priv_in;
   endproperty
   a_ap_priv: assert property (p_ap_priv)
      else $error("privileged-only region misjudged");

   property p_ap_ro;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      hit && attr[`MPC_RAS_AP_HI] && attr[`MPC_RAS_AP_LO+1] &&
      acc_write_in |-> !allow;
   endproperty
   a_ap_ro: assert property (p_ap_ro)
      else $error("write allowed to read-only region");

   property p_ap_pro;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      hit && attr[`MPC_RAS_AP_HI:`MPC_RAS_AP_LO] == `MPC_AP_PRO
      && !acc_priv_in |-> !allow;
   endproperty
   a_ap_pro: assert property (p_ap_pro)
      else $error("user access allowed to privileged-ro region");

   property p_strong;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      hit && attr[`MPC_RAS_TEX_HI:`MPC_RAS_TEX_LO] == `MPC_TEX_LEGACY
      && !attr[`MPC_RAS_C] |-> sh && mt != MPC_MT_NORMAL;
   endproperty
   a_strong: assert property (p_strong)
      else $error("legacy uncached type decoded wrong");

   property p_cached;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      hit && attr[`MPC_RAS_TEX_HI] |->
      mt == MPC_MT_NORMAL &&
      ip == mpc_policy_t'(attr[`MPC_RAS_C:`MPC_RAS_B]);
   endproperty
   a_cached: assert property (p_cached)
      else $error("cached type inner policy wrong");

   property p_status;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      s_fault_access |=> mmf_status_out[`MPC_MMF_IACC] ||
                         mmf_status_out[`MPC_MMF_DACC];
   endproperty
   a_status: assert property (p_status)
      else $error("fault status not recorded");

   property p_rnr_valid;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      ce_in && reg_sel_in && reg_wr_in && is_rba &&
      reg_wdata_in[`MPC_RBA_VALID] |=> cur == $past(wreg);
   endproperty
   a_rnr_valid: assert property (p_rnr_valid)
      else $error("valid base write did not select region");
endmodule // mpc_region_check

// >>> sim/mpc_core_model.sv
// processor-side model: register stores and load/store/fetch checks
`timescale 1ns/1ps
`include "mpc_map.svh"
module mpc_core_model (
   input  wire logic        clk_sys_in,
   input  wire logic [31:0] reg_rdata_in,
   output logic             reg_sel_out,
   output logic             reg_wr_out,
   output logic [31:0]      reg_addr_out,
   output logic [3:0]       reg_be_out,
   output logic [31:0]      reg_wdata_out,
   output logic             acc_valid_out,
   output logic [31:0]      acc_addr_out,
   output logic             acc_write_out,
   output logic             acc_priv_out,
   output logic             acc_fetch_out
);
   // ----------------------------------------
   // bus idle values at time zero
   // ----------------------------------------
   initial begin
      reg_sel_out = 1'b0;
      reg_wr_out = 1'b0;
      reg_addr_out = 32'h0;
      reg_be_out = 4'hf;
      reg_wdata_out = 32'h0;
      acc_valid_out = 1'b0;
      acc_addr_out = 32'h0;
      acc_write_out = 1'b0;
      acc_priv_out = 1'b0;
      acc_fetch_out = 1'b0;
   end
   // one store; request stays up so stores can run back to back
   task automatic wr(input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] be);
      @(posedge clk_sys_in);
      reg_sel_out <= 1'b1;
      reg_wr_out <= 1'b1;
      reg_addr_out <= a;
      reg_be_out <= be;
      reg_wdata_out <= d;
   endtask
   // release: lines turn over so stale values never look valid
   task automatic idle();
      @(posedge clk_sys_in);
      reg_sel_out <= 1'b0;
      reg_addr_out <= ~reg_addr_out;
      reg_wdata_out <= ~reg_wdata_out;
   endtask
   // one load; data arrives one cycle after the request edge
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge clk_sys_in);
      reg_sel_out <= 1'b1;
      reg_wr_out <= 1'b0;
      reg_addr_out <= a;
      idle();
      #1 d = reg_rdata_in;
   endtask
   // region set-up as software does it
   task automatic setup(input logic [31:0] n, input logic [31:0] base,
                        input logic [31:0] attr);
      wr(`MPC_ADDR_RNS, n, 4'hf);
      wr(`MPC_ADDR_RAS, 32'h0, 4'hf);
      wr(`MPC_ADDR_RNS, n, 4'hf);
      wr(`MPC_ADDR_RBA, base, 4'hf);
      wr(`MPC_ADDR_RAS, attr, 4'hf);
      idle();
      @(posedge clk_sys_in);
   endtask
   // one checked access in the address phase
   task automatic acc(input logic [31:0] a, input logic w, input logic p,
                      input logic f);
      @(posedge clk_sys_in);
      acc_valid_out <= 1'b1;
      acc_addr_out <= a;
      acc_write_out <= w;
      acc_priv_out <= p;
      acc_fetch_out <= f;
      @(posedge clk_sys_in);
      acc_valid_out <= 1'b0;
      acc_addr_out <= ~a;
      #1;
   endtask
endmodule // mpc_core_model

// >>> sim/testbench.sv
// self-checking bench for the region checker
`timescale 1ns/1ps
`include "mpc_map.svh"
module testbench
   import mpc_pkg::*;
;
   localparam logic [31:0] RNS  = `MPC_ADDR_RNS;
   localparam logic [31:0] RBA  = `MPC_ADDR_RBA;
   localparam logic [31:0] RAS  = `MPC_ADDR_RAS;
   localparam logic [31:0] BASE = 32'h2000_0000;
   localparam logic [31:0] ADR  = 32'h2000_0010;
   logic         clk_sys = 1'b0;
   logic         rstn = 1'b0;
   logic         mmf_clear = 1'b0;
   logic         ce = 1'b1;
   logic         sel, rw, vld, aw, apr, af, done, flt, exc, sh;
   logic [3:0]   be;
   logic [7:0]   st;
   logic [31:0]  addr, wd, rdata, aa, maddr;
   mpc_memtype_t mt;
   mpc_policy_t  pi, po;
   int           err_total = 0;
   int           n_compared = 0;
   mpc_core_model i_mpc_core_model (.clk_sys_in(clk_sys),
      .reg_rdata_in(rdata), .reg_sel_out(sel), .reg_wr_out(rw),
      .reg_addr_out(addr), .reg_be_out(be), .reg_wdata_out(wd),
      .acc_valid_out(vld), .acc_addr_out(aa), .acc_write_out(aw),
      .acc_priv_out(apr), .acc_fetch_out(af));
   mpc_region_check i_mpc_region_check (.clk_sys_in(clk_sys),
      .rstn_in(rstn), .ce_in(ce), .reg_sel_in(sel), .reg_wr_in(rw),
      .reg_addr_in(addr), .reg_be_in(be), .reg_wdata_in(wd),
      .reg_rdata_out(rdata), .acc_valid_in(vld), .acc_addr_in(aa),
      .acc_write_in(aw), .acc_priv_in(apr), .acc_fetch_in(af),
      .acc_done_out(done), .acc_fault_out(flt), .mem_type_out(mt),
      .shareable_out(sh), .inner_pol_out(pi), .outer_pol_out(po),
      .mmf_exc_out(exc), .mmf_clear_in(mmf_clear),
      .mmf_status_out(st), .mmf_addr_out(maddr));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   initial forever #5 clk_sys = ~clk_sys;
   // attribute word: 1 KB region, enabled
   function automatic logic [31:0] mk(input logic [2:0] ap,
      input logic [2:0] type_extension_field, input logic c, input logic b, input logic s);
      mk = {5'h0, ap, 2'h0, type_extension_field, s, c, b, 10'h0, 5'h9, 1'b1};
   endfunction
   // expected denial per permission code and access kind
   function automatic logic fexp(input logic [2:0] ap, input logic w,
                                 input logic p);
      case (ap)
         3'h1: fexp = !p;
         3'h2: fexp = !p && w;
         3'h3: fexp = 1'b0;
         3'h5: fexp = w || !p;
         3'h6, 3'h7: fexp = w;
         default: fexp = 1'b1;
      endcase
   endfunction
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         $display("unexpected %s exp %h seen %h", n, e, s);
         err_total++;
      end
   endtask
   task automatic rchk(input logic [31:0] a, input logic [31:0] e,
                       input string n);
      logic [31:0] d;
      i_mpc_core_model.rd(a, d);
      chk(n, e, d);
   endtask
   task automatic achk(input logic [31:0] a, input logic w, input logic p,
                       input logic f, input logic e);
      i_mpc_core_model.acc(a, w, p, f);
      chk("done", 32'h1, {31'h0, done});
      chk("fault", {31'h0, e}, {31'h0, flt});
   endtask
   task automatic ty(input logic [2:0] type_extension_field, input logic c, input logic b,
      input logic s, input mpc_memtype_t m, input logic h,
      input mpc_policy_t pin, input mpc_policy_t pout);
      i_mpc_core_model.setup(32'h0, BASE, mk(3'h3, type_extension_field, c, b, s));
      achk(ADR, 1'b0, 1'b1, 1'b0, 1'b0);
      chk("type", {30'h0, m}, {30'h0, mt});
      chk("share", {31'h0, h}, {31'h0, sh});
      if (m == MPC_MT_NORMAL) begin
         chk("inner", {30'h0, pin}, {30'h0, pi});
         chk("outer", {30'h0, pout}, {30'h0, po});
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      rchk(RNS, 32'h0, "select");
      rchk(RAS, 32'h0, "attr");
      i_mpc_core_model.setup(32'h2, 32'h2000_0400,
                             mk(3'h3, 3'h0, 1'b1, 1'b0, 1'b0));
      rchk(RNS, 32'h2, "select");
      rchk(RBA, 32'h2000_0402, "base");
      rchk(RAS, 32'h0302_0013, "attr");
      i_mpc_core_model.wr(RAS, 32'hffff_fffe, 4'hf);
      rchk(RAS, `MPC_RAS_WMASK & 32'hffff_fffe, "attr mask");
      rchk(32'he000edbc, 32'h0, "unmapped");
      $display("register test finished");
   endtask
   task automatic t_ap();
      logic [2:0] ap;
      for (int i = 0; i < 8; i++) begin
         ap = i[2:0];
         // code 100 is unpredictable, so it is skipped
         if (ap != 3'h4) begin
            i_mpc_core_model.setup(32'h0, BASE,
                                   mk(ap, 3'h0, 1'b1, 1'b0, 1'b0));
            for (int k = 0; k < 4; k++) begin
               achk(ADR, k[0], k[1], 1'b0, fexp(ap, k[0], k[1]));
            end
         end
      end
      achk(32'h6000_0000, 1'b0, 1'b1, 1'b0, 1'b0);
      achk(32'h6000_0000, 1'b0, 1'b0, 1'b0, 1'b1);
      $display("permission test finished");
   endtask
   task automatic t_type();
      ty(3'h0, 1'b0, 1'b0, 1'b0, MPC_MT_STRONG, 1'b1, MPC_POL_NC, MPC_POL_NC);
      ty(3'h0, 1'b0, 1'b1, 1'b0, MPC_MT_DEVICE, 1'b1, MPC_POL_NC, MPC_POL_NC);
      ty(3'h0, 1'b1, 1'b0, 1'b0, MPC_MT_NORMAL, 1'b0, MPC_POL_WT, MPC_POL_WT);
      ty(3'h0, 1'b1, 1'b0, 1'b1, MPC_MT_NORMAL, 1'b1, MPC_POL_WT, MPC_POL_WT);
      ty(3'h0, 1'b1, 1'b1, 1'b1, MPC_MT_NORMAL, 1'b1, MPC_POL_WB, MPC_POL_WB);
      ty(3'h1, 1'b0, 1'b0, 1'b1, MPC_MT_NORMAL, 1'b1, MPC_POL_NC, MPC_POL_NC);
      ty(3'h1, 1'b1, 1'b1, 1'b0, MPC_MT_NORMAL, 1'b0, MPC_POL_WB_RWA, MPC_POL_WB_RWA);
      ty(3'h5, 1'b1, 1'b0, 1'b1, MPC_MT_NORMAL, 1'b1, MPC_POL_WT, MPC_POL_WB_RWA);
      ty(3'h6, 1'b0, 1'b0, 1'b0, MPC_MT_NORMAL, 1'b0, MPC_POL_NC, MPC_POL_WT);
      ty(3'h4, 1'b0, 1'b1, 1'b0, MPC_MT_NORMAL, 1'b0, MPC_POL_WB_RWA, MPC_POL_NC);
      ty(3'h7, 1'b1, 1'b1, 1'b1, MPC_MT_NORMAL, 1'b1, MPC_POL_WB, MPC_POL_WB);
      $display("attribute test finished");
   endtask
   task automatic t_fault();
      i_mpc_core_model.setup(32'h0, BASE, mk(3'h0, 3'h0, 1'b1, 1'b0, 1'b0));
      // a denied access while the clock enable is low leaves no trace
      @(posedge clk_sys);
      ce <= 1'b0;
      i_mpc_core_model.acc(ADR, 1'b1, 1'b1, 1'b0);
      chk("frozen done", 32'h0, {31'h0, done});
      chk("frozen exception", 32'h0, {31'h0, exc});
      @(posedge clk_sys);
      ce <= 1'b1;
      achk(ADR, 1'b1, 1'b1, 1'b0, 1'b1);
      chk("exception", 32'h1, {31'h0, exc});
      chk("status", 32'h82, {24'h0, st & 8'h82});
      chk("fault addr", ADR, maddr);
      @(posedge clk_sys);
      mmf_clear <= 1'b1;
      #1 chk("exception", 32'h0, {31'h0, exc});
      @(posedge clk_sys);
      mmf_clear <= 1'b0;
      #1 chk("status", 32'h0, {24'h0, st});
      i_mpc_core_model.setup(32'h0, BASE,
         mk(3'h3, 3'h0, 1'b1, 1'b0, 1'b0) | 32'h1000_0000);
      achk(ADR, 1'b0, 1'b1, 1'b1, 1'b1);
      chk("status", 32'h1, {24'h0, st & 8'h01});
      achk(ADR, 1'b0, 1'b1, 1'b0, 1'b0);
      $display("fault test finished");
   endtask
   task automatic t_alias();
      i_mpc_core_model.setup(32'h0, BASE, mk(3'h3, 3'h0, 1'b1, 1'b0, 1'b0));
      i_mpc_core_model.wr(32'he000edac, BASE | 32'h15, 4'hf);
      i_mpc_core_model.wr(32'he000edb0, mk(3'h6, 3'h0, 1'b1, 1'b0, 1'b0), 4'hf);
      i_mpc_core_model.idle();
      achk(ADR, 1'b1, 1'b1, 1'b0, 1'b1);
      rchk(RNS, 32'h5, "select");
      i_mpc_core_model.wr(RAS, 32'h0, 4'hf);
      i_mpc_core_model.idle();
      achk(ADR, 1'b1, 1'b1, 1'b0, 1'b0);
      i_mpc_core_model.wr(RNS, 32'h0, 4'hf);
      // upper halfword store at its own byte address
      i_mpc_core_model.wr(RAS + 32'h2, 32'h0600_0000, 4'hc);
      i_mpc_core_model.idle();
      achk(ADR, 1'b1, 1'b1, 1'b0, 1'b1);
      rchk(RAS, 32'h0600_0013, "attr half");
      $display("alias test finished");
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      results();
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      t_regs();
      t_ap();
      t_type();
      t_fault();
      t_alias();
      results();
   end
endmodule // testbench
